// [rtl/sbsram_pkg.sv]
// Package for the synchronous burst SRAM cycle decoder
package sbsram_pkg;
  localparam int SBS_LANES = 4;
  localparam int SBS_LANE_W = 9;
  localparam int SBS_DATA_W = SBS_LANES * SBS_LANE_W;
  localparam int SBS_ADDR_W = 18;
  localparam int SBS_DEPTH = 1 << SBS_ADDR_W;
  localparam logic [1:0] SBS_BURST_START = 2'h0;
  localparam logic [1:0] SBS_BURST_STEP = 2'h1;
  localparam int SBS_SLEEP_DELAY = 2;
  // Recovery time in ns, and the least number of 5 ns cycles it covers
  localparam int SBS_CLK_PERIOD_PS = 5000;
  localparam int SBS_WAKE_NS = 20;
  localparam int SBS_WAKE_CYC = (SBS_WAKE_NS * 1000 + SBS_CLK_PERIOD_PS - 1) / SBS_CLK_PERIOD_PS;
  localparam int SBS_CNT_W = 4;

  typedef enum logic [4:0]
  {
    SBS_IDLE = 5'h01,
    SBS_READ = 5'h02,
    SBS_WRITE = 5'h04,
    SBS_DESEL = 5'h08,
    SBS_SLEEP = 5'h10
  } sbs_state_e;

  // Write controls of one cycle
  typedef struct packed
  {
    logic global_write_n;
    logic byte_write_n;
    logic [SBS_LANES-1:0] lane_wr_n;
  } sbs_wctl_s;

  // Chip enables and burst controls of one cycle
  typedef struct packed
  {
    logic chip_sel_first_n;
    logic chip_sel_second;
    logic chip_sel_third_n;
    logic proc_addr_strobe_n;
    logic ctrl_addr_strobe_n;
    logic burst_step_n;
  } sbs_ctl_s;
endpackage

// [rtl/sbsram_decode.sv]
// Cycle decoder and storage of a pipelined single-cycle-deselect burst SRAM
`timescale 1ns/1ps
`default_nettype none
module sbsram_decode
  import sbsram_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire sbs_ctl_s ctl,
  input wire sbs_wctl_s wctl,
  input wire logic [SBS_ADDR_W-1:0] addr,
  input wire logic out_enable_n,
  input wire logic linear_order_n,
  input wire logic sleep_request,
  input wire logic [SBS_DATA_W-1:0] dq_in,
  output logic [SBS_DATA_W-1:0] dq_out,
  output logic [SBS_LANES-1:0] dq_oe,
  output logic asleep
);

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  logic chip_en;
  logic wr_req;
  logic [SBS_LANES-1:0] wr_lanes;
  logic cmd_desel;
  logic cmd_rd_ext;
  logic cmd_wr_ext;
  logic burst_ok;
  logic cmd_rd_next;
  logic cmd_wr_next;
  logic cmd_rd_cur;
  logic cmd_wr_cur;

  // Combined enable true only with second high and third low
  assign chip_en = ctl.chip_sel_second & ~ctl.chip_sel_third_n;
  // Global write beats byte controls; byte write needs at least one lane
  assign wr_req = ~wctl.global_write_n | (~wctl.byte_write_n & ~(&wctl.lane_wr_n));
  assign wr_lanes = ~wctl.global_write_n ? {SBS_LANES{1'b1}} : ~wctl.lane_wr_n;
  // Processor strobe ignores write controls, so it can only start reads
  assign cmd_desel = (ctl.chip_sel_first_n & ~ctl.ctrl_addr_strobe_n)
                   | (~ctl.chip_sel_first_n & ~chip_en
                      & (~ctl.proc_addr_strobe_n | ~ctl.ctrl_addr_strobe_n));
  assign cmd_rd_ext = ~ctl.chip_sel_first_n & chip_en
                    & (~ctl.proc_addr_strobe_n
                       | (~ctl.ctrl_addr_strobe_n & ~wr_req));
  assign cmd_wr_ext = ~ctl.chip_sel_first_n & chip_en & ctl.proc_addr_strobe_n
                    & ~ctl.ctrl_addr_strobe_n & wr_req;
  // Burst commands need controller strobe high and no processor load
  assign burst_ok = ctl.ctrl_addr_strobe_n
                  & (ctl.proc_addr_strobe_n | ctl.chip_sel_first_n);
  assign cmd_rd_next = burst_ok & ~ctl.burst_step_n & ~wr_req;
  assign cmd_wr_next = burst_ok & ~ctl.burst_step_n & wr_req;
  assign cmd_rd_cur = burst_ok & ctl.burst_step_n & ~wr_req;
  assign cmd_wr_cur = burst_ok & ctl.burst_step_n & wr_req;

  // ----------------------------------------------------------------
  // Sleep control
  // ----------------------------------------------------------------
  logic [1:0] sleep_pipe;
  logic [SBS_CNT_W-1:0] wake_cnt;
  sbs_state_e state;
  sbs_state_e next_state;
  logic active;

  // Request takes effect two samples later; a single high sample puts the array to sleep
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      sleep_pipe <= 2'h0;
    else
      sleep_pipe <= {sleep_pipe[0], sleep_request};
  end

  // Recovery count runs while the request is low after sleeping
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      wake_cnt <= '0;
    else if (state == SBS_SLEEP && !sleep_request)
      wake_cnt <= wake_cnt + SBS_CNT_W'(1);
    else
      wake_cnt <= '0;
  end

  assign active = (state != SBS_SLEEP);

  // ----------------------------------------------------------------
  // Cycle state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    case (state)
      SBS_SLEEP:
      begin
        if (!sleep_request && wake_cnt >= SBS_CNT_W'(SBS_WAKE_CYC - 1))
          next_state = SBS_IDLE;
      end
      SBS_IDLE, SBS_READ, SBS_WRITE, SBS_DESEL:
      begin
        if (sleep_pipe[1])
          next_state = SBS_SLEEP;
        else if (cmd_desel)
          next_state = SBS_DESEL;
        else if (cmd_wr_ext || cmd_wr_next || cmd_wr_cur)
          next_state = SBS_WRITE;
        else if (cmd_rd_ext || cmd_rd_next || cmd_rd_cur)
          next_state = (state == SBS_IDLE && !cmd_rd_ext) ? SBS_IDLE : SBS_READ;
        else
          next_state = state;
      end
      default:
        next_state = SBS_IDLE;
    endcase
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      state <= SBS_IDLE;
    else
      state <= next_state;
  end

  // ----------------------------------------------------------------
  // Burst address counter
  // ----------------------------------------------------------------
  logic [SBS_ADDR_W-1:0] base_addr;
  logic [1:0] burst_cnt;
  logic [1:0] next_cnt;
  logic [1:0] low_bits;
  logic [SBS_ADDR_W-1:0] cur_addr;
  logic [SBS_ADDR_W-1:0] acc_addr;
  logic do_read;
  logic do_write;
  logic load_ext;

  // Linear adds the count, interleaved exclusive-ors it
  assign low_bits = linear_order_n ? (base_addr[1:0] ^ burst_cnt)
                                   : (base_addr[1:0] + burst_cnt);
  assign cur_addr = {base_addr[SBS_ADDR_W-1:2], low_bits};
  // Two-bit count wraps itself, so the fifth clock lands on the start
  assign next_cnt = burst_cnt + SBS_BURST_STEP;
  assign load_ext = active & (cmd_rd_ext | cmd_wr_ext);
  // Idle-only bursts have no live address, so only a started burst counts
  assign do_read = active & (cmd_rd_ext
                   | ((state == SBS_READ || state == SBS_WRITE) & (cmd_rd_next | cmd_rd_cur)));
  assign do_write = active & (cmd_wr_ext
                   | ((state == SBS_READ || state == SBS_WRITE) & (cmd_wr_next | cmd_wr_cur)));

  // Next address for the access in this cycle
  always_comb
  begin
    if (load_ext)
      acc_addr = addr;
    else if (cmd_rd_next || cmd_wr_next)
      acc_addr = {base_addr[SBS_ADDR_W-1:2],
                  linear_order_n ? (base_addr[1:0] ^ next_cnt)
                                 : (base_addr[1:0] + next_cnt)};
    else
      acc_addr = cur_addr;
  end

  // Counter steps on every burst advance in the read or write state, dummy reads with output off included
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      base_addr <= '0;
      burst_cnt <= SBS_BURST_START;
    end
    else if (load_ext)
    begin
      base_addr <= addr;
      burst_cnt <= SBS_BURST_START;
    end
    else if ((do_read || do_write) && (cmd_rd_next || cmd_wr_next))
      burst_cnt <= next_cnt;
  end

  // ----------------------------------------------------------------
  // Storage array
  // ----------------------------------------------------------------
  logic [SBS_DATA_W-1:0] mem [SBS_DEPTH];

  // Write lands in the same clock; the array needs no reset
  always_ff @(posedge clock)
  begin
    if (do_write)
    begin
      for (int i = 0; i < SBS_LANES; i++)
        if (wr_lanes[i])
          mem[acc_addr][i*SBS_LANE_W +: SBS_LANE_W] <= dq_in[i*SBS_LANE_W +: SBS_LANE_W];
    end
  end

  // ----------------------------------------------------------------
  // Output pipeline
  // ----------------------------------------------------------------
  // One stage: data is registered from the captured address
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      dq_out <= '0;
    else if (do_read)
      dq_out <= mem[acc_addr];
  end

  // Drivers only for a read; writes and deselects turn them off at once.
  // Output enable is sampled here, since only one clock exists.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      dq_oe <= '0;
    else if (do_read && !out_enable_n)
      dq_oe <= {SBS_LANES{1'b1}};
    else
      dq_oe <= '0;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      asleep <= 1'b0;
    else
      asleep <= (next_state == SBS_SLEEP);
  end

endmodule // sbsram_decode
`default_nettype wire

// [dv/sbs_ctrl_model.sv]
// Controller-side model that presents one bus command per clock
`timescale 1ns/1ps
`default_nettype none
module sbs_ctrl_model
  import sbsram_pkg::*;
(
  input wire logic clock,
  output var sbs_ctl_s ctl,
  output var sbs_wctl_s wctl,
  output logic [SBS_ADDR_W-1:0] addr,
  output logic [SBS_DATA_W-1:0] dq_in,
  output logic out_enable_n
);
  // Idle is a deselect, not a burst suspend
  initial
  begin
    ctl = 6'h2d;
    wctl = 6'h3f;
    addr = '0;
    dq_in = '0;
    out_enable_n = 1'b0;
  end
  // New command just after an edge; write data toggles when wctl is all ones so it is never trusted
  task automatic cmd(input logic [5:0] c, input logic [5:0] w, input logic [17:0] a,
      input logic [35:0] d, input logic oe_n);
    @(posedge clock);
    #1;
    ctl = c;
    wctl = w;
    addr = a;
    dq_in = (w == 6'h3f) ? ~dq_in : d;
    out_enable_n = oe_n;
  endtask
endmodule // sbs_ctrl_model
`default_nettype wire

// [dv/sbsram_decode_assertions.sv]
// Checker of the burst SRAM cycle decoder ports
`timescale 1ns/1ps
`default_nettype none
module sbsram_decode_assertions
  import sbsram_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire sbs_ctl_s ctl,
  input wire sbs_wctl_s wctl,
  input wire logic [SBS_ADDR_W-1:0] addr,
  input wire logic out_enable_n,
  input wire logic linear_order_n,
  input wire logic sleep_request,
  input wire logic [SBS_DATA_W-1:0] dq_in,
  input wire logic [SBS_DATA_W-1:0] dq_out,
  input wire logic [SBS_LANES-1:0] dq_oe,
  input wire logic asleep
);
  logic wr, en, desel, rd_beg;
  // Command classes of the sampled controls
  assign wr = !wctl.global_write_n || (!wctl.byte_write_n && wctl.lane_wr_n != 4'hf);
  assign en = ctl.chip_sel_second && !ctl.chip_sel_third_n;
  assign desel = ctl.chip_sel_first_n ? !ctl.ctrl_addr_strobe_n
    : !en && !(ctl.proc_addr_strobe_n && ctl.ctrl_addr_strobe_n);
  assign rd_beg = !ctl.chip_sel_first_n && en
    && (!ctl.proc_addr_strobe_n || (!ctl.ctrl_addr_strobe_n && !wr));
  default clocking dc @(posedge clock);
  endclocking
  default disable iff (rst);
  a_write_undriven: assert property (wr && !desel && !rd_beg |=> dq_oe == 4'h0)
    else $error("lanes driven after a write");
  a_desel_off: assert property (desel |=> dq_oe == 4'h0)
    else $error("lanes driven after a deselect");
  a_read_drives: assert property (rd_beg && !asleep && !sleep_request && !out_enable_n
    |=> dq_oe == 4'hf) else $error("read start did not drive lanes");
  a_oe_gates: assert property (out_enable_n |=> dq_oe == 4'h0)
    else $error("lanes driven with output enable high");
  a_lanes_whole: assert property (dq_oe == 4'h0 || dq_oe == 4'hf)
    else $error("partial lane drive");
  a_sleep_entry: assert property (sleep_request [*2] |-> ##[1:2] asleep)
    else $error("sleep not entered");
  a_wake_bound: assert property (!sleep_request [*8] |-> !asleep)
    else $error("sleep held too long");
  a_sleep_cause: assert property ($rose(asleep) |-> $past(sleep_request, 2))
    else $error("sleep without request");
endmodule // sbsram_decode_assertions
`default_nettype wire

// [dv/tb_sbsram_decode.sv]
// Self-checking bench for the burst SRAM cycle decoder
`timescale 1ns/1ps
`default_nettype none
module tb_sbsram_decode
  import sbsram_pkg::*;
  ;
  localparam logic [5:0] DES = 6'h2d, RDP = 6'h13, BEG = 6'h15, CONT = 6'h16, SUSP = 6'h17;
  localparam logic [5:0] CONE = 6'h2e, NOEN = 6'h03, RD = 6'h3f, WALL = 6'h1f;
  logic clock, rst = 1'b1, linear_order_n = 1'b0, sleep_request = 1'b0, asleep, pend = 1'b0;
  sbs_ctl_s ctl;
  sbs_wctl_s wctl;
  logic [SBS_ADDR_W-1:0] addr;
  logic [SBS_DATA_W-1:0] dq_in, dq_out, p_q, e;
  logic [SBS_LANES-1:0] dq_oe, p_oe;
  logic out_enable_n;
  int n_mismatch = 0, tests_run = 0, cycles = 0;
  sbsram_decode u_sbsram_decode (.clock(clock), .rst(rst), .ctl(ctl), .wctl(wctl),
    .addr(addr), .out_enable_n(out_enable_n), .linear_order_n(linear_order_n),
    .sleep_request(sleep_request), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
    .asleep(asleep));
  sbs_ctrl_model u_sbs_ctrl_model (.clock(clock), .ctl(ctl), .wctl(wctl), .addr(addr),
    .dq_in(dq_in), .out_enable_n(out_enable_n));
  // 200 MHz clock
  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // Hang guard, far above the 66 cycles the run needs
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_mismatch++;
      end_of_test();
    end
  end
  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One command per cycle; the previous command's answer is judged one clock on
  task automatic step(input logic [5:0] c, input logic [5:0] w, input logic [17:0] a,
      input logic [35:0] d, input logic oe_n, input logic [3:0] eoe, input logic [35:0] eq);
    u_sbs_ctrl_model.cmd(c, w, a, d, oe_n);
    if (pend)
    begin
      check({32'h0, dq_oe}, {32'h0, p_oe});
      if (p_oe == 4'hf)
        check(dq_out, p_q);
    end
    pend = 1'b1;
    p_oe = eoe;
    p_q = eq;
  endtask
  task automatic sc_lanes();
    logic [35:0] d;
    e = 36'h3c5a69788;
    step(BEG, WALL, 18'h100, e, 1'b0, 4'h0, e);
    for (int i = 0; i < 4; i++)
    begin
      d = ~e + 36'(i);
      step(BEG, {2'b10, ~(4'h1 << i)}, 18'h100, d, 1'b0, 4'h0, e);
      e[i*9 +: 9] = d[i*9 +: 9];
    end
    step(BEG, RD, 18'h100, 36'h0, 1'b0, 4'hf, e);
    step(RDP, WALL, 18'h100, ~e, 1'b0, 4'hf, e);
    step(BEG, 6'h2f, 18'h100, 36'h0, 1'b0, 4'hf, e);
    step(NOEN, WALL, 18'h100, ~e, 1'b0, 4'h0, e);
    step(DES, WALL, 18'h100, ~e, 1'b0, 4'h0, e);
    step(BEG, RD, 18'h100, 36'h0, 1'b1, 4'h0, e);
  endtask
  // Write a four-beat burst, read it back past the wrap, then suspend
  task automatic sc_burst(input logic ord);
    logic [35:0] bm [4];
    logic [1:0] n;
    linear_order_n = ord;
    for (int i = 0; i < 4; i++)
    begin
      n = ord ? 2'(1 ^ i) : 2'(1 + i);
      bm[n] = 36'h9a5c3e170 ^ 36'(i * 3 + ord);
      step(i ? CONT : BEG, WALL, 18'h201, bm[n], 1'b0, 4'h0, 36'h0);
    end
    for (int i = 0; i < 5; i++)
    begin
      n = ord ? 2'(1 ^ i) : 2'(1 + i);
      step(i == 0 ? BEG : (i == 3 ? CONE : CONT), RD, 18'h201, 36'h0, 1'(i == 2),
        i == 2 ? 4'h0 : 4'hf, bm[n]);
    end
    step(SUSP, RD, 18'h201, 36'h0, 1'b0, 4'hf, bm[1]);
    step(SUSP, WALL, 18'h201, 36'h0a5, 1'b0, 4'h0, 36'h0);
    step(BEG, RD, 18'h201, 36'h0, 1'b0, 4'hf, 36'h0a5);
  endtask
  task automatic sc_sleep();
    sleep_request = 1'b1;
    repeat (4) step(DES, RD, 18'h0, 36'h0, 1'b0, 4'h0, 36'h0);
    check({35'h0, asleep}, 36'h1);
    step(BEG, WALL, 18'h100, ~e, 1'b0, 4'h0, 36'h0);
    sleep_request = 1'b0;
    repeat (8) step(DES, RD, 18'h0, 36'h0, 1'b0, 4'h0, 36'h0);
    check({35'h0, asleep}, 36'h0);
    step(BEG, RD, 18'h100, 36'h0, 1'b0, 4'hf, e);
    step(DES, RD, 18'h0, 36'h0, 1'b0, 4'h0, 36'h0);
  endtask
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Reset for 16 cycles, then the scenarios in turn
  initial
  begin
    repeat (16) @(posedge clock);
    check({32'h0, dq_oe}, 36'h0);
    #1;
    rst = 1'b0;
    sc_lanes();
    sc_burst(1'b0);
    sc_burst(1'b1);
    sc_sleep();
    end_of_test();
  end
endmodule // tb_sbsram_decode
bind sbsram_decode sbsram_decode_assertions u_sbsram_decode_assertions (.clock(clock),
  .rst(rst), .ctl(ctl), .wctl(wctl), .addr(addr), .out_enable_n(out_enable_n),
  .linear_order_n(linear_order_n), .sleep_request(sleep_request), .dq_in(dq_in),
  .dq_out(dq_out), .dq_oe(dq_oe), .asleep(asleep));
`default_nettype wire
